/* File: thread_count_pkg.sv */
/*
  Constants shared by the thread-qualified event counter: register offsets,
  field positions, reset values, source codes and the privilege test.
  Assumes a 32-bit register port with an 8-bit byte address.
*/
package thread_count_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_EVENT_SELECT  = 8'h00; // event_select_reg
  localparam logic [7:0] OFF_COUNTER_CFG   = 8'h04; // counter_config_reg
  localparam logic [7:0] OFF_COUNT         = 8'h08; // Counter value
  localparam logic [7:0] OFF_STATUS        = 8'h0c; // Sticky events, W1C
  localparam logic [7:0] OFF_MASK          = 8'h10; // Interrupt mask
  localparam logic [7:0] OFF_STAMP         = 8'h14; // Time-stamp count
  localparam logic [7:0] OFF_POWER_STATE   = 8'h18; // Live power state
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned T1_USER_BIT   = 0;  // thread1_user_qual
  localparam int unsigned T1_KERNEL_BIT = 1;  // thread1_kernel_qual
  localparam int unsigned T0_USER_BIT   = 2;  // thread0_user_qual
  localparam int unsigned T0_KERNEL_BIT = 3;  // thread0_kernel_qual
  localparam int unsigned CLASS_BIT     = 4;  // 1 = shared_event_class
  localparam int unsigned SRC_LSB       = 5;  // Source select, 3 bits
  localparam int unsigned ENABLE_BIT    = 12; // Counter enable
  localparam int unsigned ST_COUNT_OVF  = 0;  // Counter overflow
  localparam int unsigned ST_STAMP_WRAP = 1;  // Time-stamp wrap
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic       ENABLE_RESET = 1'b0;
  localparam logic [1:0] FLAGS_RESET  = 2'h0;
  localparam logic [2:0] SRC_NONE     = 3'h0; // Nothing counted
  localparam logic [2:0] SRC_EVENT    = 3'h1; // External event
  localparam logic [2:0] SRC_NONHALT  = 3'h2; // Non-halted cycles
  localparam logic [2:0] SRC_NONSLEEP = 3'h3; // Non-sleep cycles
  localparam logic [2:0] SRC_REFTICK  = 3'h4; // Constant reference ticks
  localparam logic [1:0] KERNEL_CPL   = 2'h0; // Privilege level 0

  // Level test: user bit covers levels 1-3, kernel bit covers level 0
  function automatic logic level_enabled(input logic [1:0] current_privilege_level,
                                         input logic user_q,
                                         input logic kernel_q);
    level_enabled = (current_privilege_level == KERNEL_CPL) ? kernel_q : user_q;
  endfunction
endpackage

/* File: priv_thread_qualifier.sv */
/*
  Combinational thread and privilege qualification of one occurrence.
  Assumes the caller says on which threads the occurrence lies.
*/
`timescale 1ns/100ps
module priv_thread_qualifier (
  input  wire logic [3:0] quals,       // Qualifier bits, select layout
  input  wire logic       shared,      // Occurrence is shared class
  input  wire logic [1:0] thread0_cpl, // Thread 0 privilege level
  input  wire logic [1:0] thread1_cpl, // Thread 1 privilege level
  input  wire logic       hit0,        // Occurrence on thread 0
  input  wire logic       hit1,        // Occurrence on thread 1
  output logic            pass         // Occurrence is counted
);
  logic u0, k0, u1, k1, u_any, k_any;
  assign u0 = quals[thread_count_pkg::T0_USER_BIT];
  assign k0 = quals[thread_count_pkg::T0_KERNEL_BIT];
  assign u1 = quals[thread_count_pkg::T1_USER_BIT];
  assign k1 = quals[thread_count_pkg::T1_KERNEL_BIT];
  assign u_any = u0 | u1;
  assign k_any = k0 | k1;

  // Per-thread: each thread judged by its own bits only; shared: merged
  always_comb begin
    if (!shared) begin
      pass = (hit0 && thread_count_pkg::level_enabled(thread0_cpl, u0, k0))
          || (hit1 && thread_count_pkg::level_enabled(thread1_cpl, u1, k1));
    end else begin
      pass = (hit0 || hit1)
          && ((u_any && k_any)
          || thread_count_pkg::level_enabled(thread0_cpl, u_any, k_any)
          || thread_count_pkg::level_enabled(thread1_cpl, u_any, k_any));
    end
  end
endmodule

/* File: tick_counter.sv */
/*
  Loadable up-counter with a one-cycle wrap pulse.
  Assumes load has priority over increment.
*/
`timescale 1ns/100ps
module tick_counter #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clock,      // Core clock
  input  wire logic             arst_n,     // Async reset, active low
  input  wire logic             load,       // Load load_value
  input  wire logic [WIDTH-1:0] load_value, // Value to load
  input  wire logic             inc,        // Add one this cycle
  output logic      [WIDTH-1:0] value,      // Current count
  output logic                  wrap        // Pulse after all-ones + 1
);
  typedef struct packed {
    logic [WIDTH-1:0] count_reg;
    logic             wrap_reg;
  } cnt_state_t;
  cnt_state_t st_reg, st_next;

  // Next count: load, else step by one, else hold
  always_comb begin
    st_next = st_reg;
    st_next.wrap_reg = 1'b0;
    if (load) begin
      st_next.count_reg = load_value;
    end else if (inc) begin
      st_next.count_reg = st_reg.count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      st_next.wrap_reg  = &st_reg.count_reg;
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.count_reg;
  assign wrap  = st_reg.wrap_reg;
endmodule

/* File: thread_qualified_event_counter.sv */
/*
  Thread-qualified performance counter with cycle-count sources and a
  free time-stamp counter, reached over a plain register port.
  Assumes all inputs are synchronous to clock; event_pulse is one cycle
  per occurrence; the register master never issues read and write at once.
*/
// Our own choices: the address map and the strobed register port.
// Functional notes
// - Event thread is APIC identifier bit 0.
// - Events classed per-thread or shared.
// - Per-thread thread 0 event uses only thread 0 bits.
// - Per-thread: each thread tested by own bits.
// - Shared: merged bits, both levels count always.
// - Counters stop only when both threads halt.
// - Time stamp steps unless in deep sleep.
// - Non-halted cycles count per active thread.
// - Non-sleep cycles count package-wide, unqualified.
// - Constant reference ticks are a countable source.
// - Counter overflow can raise an interrupt.
// - User bit covers levels 1-3, kernel level 0.
`timescale 1ns/100ps
module thread_qualified_event_counter #(
  parameter int unsigned COUNT_W = 32 // Counter and time-stamp width
) (
  input  wire logic        clock,              // 40 MHz core clock
  input  wire logic        arst_n,             // Async reset, active low
  input  wire logic [7:0]  reg_addr,           // Register byte address
  input  wire logic [31:0] reg_wdata,          // Write data
  input  wire logic        reg_wr,             // Write strobe
  input  wire logic        reg_rd,             // Read strobe
  output logic      [31:0] reg_rdata,          // Read data, next cycle
  input  wire logic        event_pulse,        // One occurrence
  input  wire logic        event_apic_lsb,     // APIC id bit 0 of source
  input  wire logic        event_shared,       // Occurrence is shared class
  input  wire logic [1:0]  thread0_cpl,        // Thread 0 privilege level
  input  wire logic [1:0]  thread1_cpl,        // Thread 1 privilege level
  input  wire logic        thread0_halted,     // Thread 0 halted
  input  wire logic        thread1_halted,     // Thread 1 halted
  input  wire logic        thread0_power_save, // Thread 0 power-saving
  input  wire logic        thread1_power_save, // Thread 1 power-saving
  input  wire logic        pkg_sleep,          // Package asleep
  input  wire logic        pkg_power_save,     // Package power-saving
  input  wire logic        pkg_deep_sleep,     // Package in deep sleep
  input  wire logic        ref_tick,           // Constant-rate tick
  output logic             irq                 // Level interrupt
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  select_reg;  // Qualifiers, class and source
    logic        enable_reg;  // Counter enable
    logic [1:0]  status_reg;  // Sticky events
    logic [1:0]  mask_reg;    // Interrupt mask
    logic [31:0] rdata_reg;   // Read data
    logic        irq_reg;     // Interrupt output
  } top_state_t;
  top_state_t st_reg, st_next;

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  logic [3:0]         quals;       // Four qualifier bits
  logic               sel_shared;  // Class bit of the select register
  logic [2:0]         src;         // Selected source
  logic               powered;     // Counter hardware not powered down
  logic               thread0_run; // Thread 0 neither halted nor saving
  logic               thread1_run; // Thread 1 neither halted nor saving
  logic               hit0;        // Occurrence attributed to thread 0
  logic               hit1;        // Occurrence attributed to thread 1
  logic               q_shared;    // Class handed to the qualifier
  logic               q_pass;      // Qualifier verdict
  logic               src_hit;     // Source wants a count
  logic               cnt_inc;     // Counter steps this cycle
  logic               cnt_load;    // Software writes the counter
  logic [COUNT_W-1:0] cnt_value;   // Counter value
  logic               cnt_wrap;    // Counter overflowed
  logic               stamp_inc;   // Time stamp steps this cycle
  logic [COUNT_W-1:0] stamp_value; // Time-stamp value
  logic               stamp_wrap;  // Time stamp wrapped
  logic               stamp_load;  // Software writes the time stamp

  assign quals      = st_reg.select_reg[3:0];
  assign sel_shared = st_reg.select_reg[thread_count_pkg::CLASS_BIT];
  assign src        = st_reg.select_reg[thread_count_pkg::SRC_LSB +: 3];

  // Hardware stays powered while at least one thread is not halted
  assign powered = !(thread0_halted && thread1_halted);

  assign thread0_run = !thread0_halted && !thread0_power_save;
  assign thread1_run = !thread1_halted && !thread1_power_save;

  // ----------------------------------------------------------------
  // Source routing into the qualifier
  // ----------------------------------------------------------------
  // Picks which threads an occurrence belongs to for each source
  always_comb begin
    hit0     = 1'b0;
    hit1     = 1'b0;
    q_shared = 1'b0;
    case (src)
      thread_count_pkg::SRC_EVENT: begin
        // Thread identity from APIC id bit 0, or both when shared
        q_shared = sel_shared || event_shared;
        hit0     = event_pulse && (q_shared || !event_apic_lsb);
        hit1     = event_pulse && (q_shared || event_apic_lsb);
      end
      thread_count_pkg::SRC_NONHALT: begin
        // Each running thread is a per-thread occurrence
        hit0 = thread0_run;
        hit1 = thread1_run;
      end
      default: begin
        // Remaining sources bypass the qualifier
        hit0 = 1'b0;
      end
    endcase
  end

  priv_thread_qualifier u_qual (
    .quals       (quals),
    .shared      (q_shared),
    .thread0_cpl (thread0_cpl),
    .thread1_cpl (thread1_cpl),
    .hit0        (hit0),
    .hit1        (hit1),
    .pass        (q_pass)
  );

  // Final verdict per source
  always_comb begin
    case (src)
      thread_count_pkg::SRC_EVENT:    src_hit = q_pass;
      thread_count_pkg::SRC_NONHALT:  src_hit = q_pass;
      // Package-wide, qualifier bits ignored
      thread_count_pkg::SRC_NONSLEEP: src_hit = !pkg_sleep && !pkg_power_save;
      // Constant-rate ticks, blind to core ratio changes
      thread_count_pkg::SRC_REFTICK:  src_hit = ref_tick;
      default:                        src_hit = 1'b0;
    endcase
  end

  // One per qualified occurrence, only while enabled and powered
  assign cnt_inc    = st_reg.enable_reg && powered && src_hit;
  assign cnt_load   = reg_wr && (reg_addr == thread_count_pkg::OFF_COUNT);
  assign stamp_inc  = !pkg_deep_sleep;
  assign stamp_load = reg_wr && (reg_addr == thread_count_pkg::OFF_STAMP);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  tick_counter #(.WIDTH(COUNT_W)) u_count (
    .clock      (clock),
    .arst_n     (arst_n),
    .load       (cnt_load),
    .load_value (reg_wdata[COUNT_W-1:0]),
    .inc        (cnt_inc),
    .value      (cnt_value),
    .wrap       (cnt_wrap)
  );

  tick_counter #(.WIDTH(COUNT_W)) u_stamp (
    .clock      (clock),
    .arst_n     (arst_n),
    .load       (stamp_load),
    .load_value (reg_wdata[COUNT_W-1:0]),
    .inc        (stamp_inc),
    .value      (stamp_value),
    .wrap       (stamp_wrap)
  );

  // ----------------------------------------------------------------
  // Register port, status and interrupt
  // ----------------------------------------------------------------
  // Writes, W1C status with set winning, read mux, interrupt level
  always_comb begin
    st_next = st_reg;
    st_next.rdata_reg = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        thread_count_pkg::OFF_EVENT_SELECT: st_next.select_reg = reg_wdata[7:0];
        thread_count_pkg::OFF_COUNTER_CFG:
          st_next.enable_reg = reg_wdata[thread_count_pkg::ENABLE_BIT];
        thread_count_pkg::OFF_STATUS: st_next.status_reg = st_reg.status_reg & ~reg_wdata[1:0];
        thread_count_pkg::OFF_MASK:   st_next.mask_reg = reg_wdata[1:0];
        default: begin
          // Other offsets: counters load themselves, rest ignored
          st_next.select_reg = st_reg.select_reg;
        end
      endcase
    end
    // Hardware events set after any clear
    if (cnt_wrap) begin
      st_next.status_reg[thread_count_pkg::ST_COUNT_OVF] = 1'b1;
    end
    if (stamp_wrap) begin
      st_next.status_reg[thread_count_pkg::ST_STAMP_WRAP] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        thread_count_pkg::OFF_EVENT_SELECT: st_next.rdata_reg = {24'h00_0000, st_reg.select_reg};
        thread_count_pkg::OFF_COUNTER_CFG:
          st_next.rdata_reg = {19'h0_0000, st_reg.enable_reg, 12'h000};
        thread_count_pkg::OFF_COUNT: st_next.rdata_reg = 32'(cnt_value);
        thread_count_pkg::OFF_STATUS: st_next.rdata_reg = {30'h0000_0000, st_reg.status_reg};
        thread_count_pkg::OFF_MASK:   st_next.rdata_reg = {30'h0000_0000, st_reg.mask_reg};
        thread_count_pkg::OFF_STAMP:  st_next.rdata_reg = 32'(stamp_value);
        thread_count_pkg::OFF_POWER_STATE:
          st_next.rdata_reg = {24'h00_0000, pkg_deep_sleep, pkg_power_save, pkg_sleep,
                               powered, thread1_power_save, thread0_power_save,
                               thread1_halted, thread0_halted};
        default: st_next.rdata_reg = 32'h0000_0000;
      endcase
    end
    st_next.irq_reg = |(st_next.status_reg & st_next.mask_reg);
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.select_reg <= thread_count_pkg::SELECT_RESET;
      st_reg.enable_reg <= thread_count_pkg::ENABLE_RESET;
      st_reg.status_reg <= thread_count_pkg::FLAGS_RESET;
      st_reg.mask_reg   <= thread_count_pkg::FLAGS_RESET;
      st_reg.rdata_reg  <= 32'h0000_0000;
      st_reg.irq_reg    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata_reg;
  assign irq       = st_reg.irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic counting_event; // Enabled, powered, external event source
  assign counting_event = st_reg.enable_reg && powered
                       && (src == thread_count_pkg::SRC_EVENT);

  sequence s_wrap_seen;
    cnt_wrap && st_reg.mask_reg[thread_count_pkg::ST_COUNT_OVF];
  endsequence

  sequence s_irq_raised;
    st_reg.status_reg[thread_count_pkg::ST_COUNT_OVF] && irq;
  endsequence

  chk_count_step: assert property (
    cnt_inc && !cnt_load |=> cnt_value == $past(cnt_value) + 1'b1)
    else $error("counter did not step by one");

  chk_count_hold: assert property (
    !cnt_inc && !cnt_load |=> cnt_value == $past(cnt_value))
    else $error("counter moved without a qualified occurrence");

  chk_both_halted: assert property (
    thread0_halted && thread1_halted |-> !cnt_inc)
    else $error("counter ran with both threads halted");

  chk_one_halted: assert property (
    st_reg.enable_reg && (src == thread_count_pkg::SRC_NONSLEEP)
    && (thread0_halted != thread1_halted) && !pkg_sleep && !pkg_power_save |-> cnt_inc)
    else $error("single halted thread stopped counting");

  chk_apic_thread: assert property (
    counting_event && !sel_shared && !event_shared && event_pulse
    && quals == 4'h3 |-> cnt_inc == event_apic_lsb)
    else $error("thread not taken from id bit 0");

  chk_t1_ignored: assert property (
    counting_event && !sel_shared && !event_shared && event_pulse && !event_apic_lsb
    && quals[3:2] == 2'h0 |-> !cnt_inc)
    else $error("thread 1 bits counted a thread 0 event");

  chk_kernel_level: assert property (
    counting_event && !sel_shared && !event_shared && event_pulse && !event_apic_lsb
    && quals == 4'h8 |-> cnt_inc == (thread0_cpl == thread_count_pkg::KERNEL_CPL))
    else $error("kernel qualifier level test wrong");

  chk_shared_all: assert property (
    counting_event && (sel_shared || event_shared) && event_pulse
    && (quals[0] || quals[2]) && (quals[1] || quals[3]) |-> cnt_inc)
    else $error("shared event with both levels not counted");

  chk_nonhalt_idle: assert property (
    src == thread_count_pkg::SRC_NONHALT && !thread0_run && !thread1_run |-> !cnt_inc)
    else $error("non-halted count with no running thread");

  chk_stamp_step: assert property (
    !stamp_load |=> stamp_value == $past(stamp_value) + ($past(stamp_inc) ? 1'b1 : 1'b0))
    else $error("time stamp step wrong");

  chk_overflow_irq: assert property (
    s_wrap_seen |=> s_irq_raised)
    else $error("overflow did not raise interrupt");

  chk_read_count: assert property (
    reg_rd && reg_addr == thread_count_pkg::OFF_COUNT |=> reg_rdata == 32'($past(cnt_value)))
    else $error("count read data wrong");
endmodule

/* File: thread_qualified_event_counter_tb.sv */
/*
  Self-checking bench for the thread-qualified event counter: reset checks,
  a table of qualification cases, then time-stamp, interrupt and reset checks.
  Assumes the design package and modules are compiled before this file.
*/
`timescale 1ns/100ps
module thread_qualified_event_counter_tb;
  // ----------------------------------------------------------------
  // Signals and case table
  // ----------------------------------------------------------------
  logic        clock, arst_n, reg_wr, reg_rd, event_pulse, event_apic_lsb, irq;
  logic        thread0_halted, thread1_halted, thread1_power_save, pkg_sleep;
  logic        event_shared, thread0_power_save, pkg_power_save;
  logic        pkg_deep_sleep, ref_tick;
  logic [1:0]  thread0_cpl, thread1_cpl;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv, v1;
  int          err_total, n_compared;
  // Row: src[15:13] sel[12:8] apic[7] c0[6:5] c1[4:3] ps1[2] sleep[1] hit[0]
  logic [15:0] rows [19] = '{16'h2461, 16'h2300, 16'h2819, 16'h2840, 16'h2191,
    16'h2298, 16'h2000, 16'h3161, 16'h38c1, 16'h3500, 16'h3609, 16'h3000,
    16'h4109, 16'h410c, 16'h4478, 16'h6001, 16'h6002, 16'h8001, 16'h0f00};
  logic [7:0]  addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};

  thread_qualified_event_counter #(.COUNT_W(32)) i_thread_qualified_event_counter (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_pulse(event_pulse), .event_apic_lsb(event_apic_lsb),
    .event_shared(event_shared), .thread0_cpl(thread0_cpl), .thread1_cpl(thread1_cpl),
    .thread0_halted(thread0_halted), .thread1_halted(thread1_halted),
    .thread0_power_save(thread0_power_save), .thread1_power_save(thread1_power_save),
    .pkg_sleep(pkg_sleep), .pkg_power_save(pkg_power_save),
    .pkg_deep_sleep(pkg_deep_sleep),
    .ref_tick(ref_tick), .irq(irq));

  // Clock of 25 ns period
  always #12.5 clock = ~clock;

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Opens the gate for three cycles: thread 1 halt, or thread 0 power-saving
  task automatic window(input logic t0);
    @(posedge clock);
    if (t0) thread0_power_save <= 1'b0;
    else thread1_halted <= 1'b0;
    repeat (3) @(posedge clock);
    if (t0) thread0_power_save <= 1'b1;
    else thread1_halted <= 1'b1;
  endtask
  // Select, load zero, open the gate, read back: one per counted cycle
  task automatic run_case(input logic [7:0] sel, input logic t0, input logic [31:0] exp);
    logic [31:0] got;
    wr(thread_count_pkg::OFF_EVENT_SELECT, {24'h0, sel});
    wr(thread_count_pkg::OFF_COUNT, 32'h0);
    window(t0);
    rd(thread_count_pkg::OFF_COUNT, got);
    check(got, exp);
  endtask
  // Bounded wait for an interrupt level
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 10) begin
      @(posedge clock);
      #1 n++;
    end
    check({31'h0, irq}, {31'h0, v});
  endtask
  // Report and end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0; arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h0; event_pulse = 1'b1; event_apic_lsb = 1'b0; ref_tick = 1'b1;
    thread0_cpl = 2'h0; thread1_cpl = 2'h0; thread0_halted = 1'b1;
    thread1_halted = 1'b1; thread1_power_save = 1'b0; pkg_sleep = 1'b0;
    pkg_deep_sleep = 1'b0; err_total = 0; n_compared = 0;
    event_shared = 1'b0; thread0_power_save = 1'b0; pkg_power_save = 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    // Reset values, unmapped place ignored on write
    wr(8'h1c, 32'hffff_ffff);
    foreach (addrs[i]) begin
      rd(addrs[i], rdv);
      check(rdv, 32'h0);
    end
    check({31'h0, irq}, 32'h0);
    // Both threads halted: counters powered down
    rd(thread_count_pkg::OFF_POWER_STATE, rdv);
    check(rdv, 32'h3);
    // Table: select, load zero, open window, read back
    wr(thread_count_pkg::OFF_COUNTER_CFG, 32'h1 << thread_count_pkg::ENABLE_BIT);
    foreach (rows[i]) begin
      event_apic_lsb <= rows[i][7];
      thread0_cpl <= rows[i][6:5];
      thread1_cpl <= rows[i][4:3];
      thread1_power_save <= rows[i][2];
      pkg_sleep <= rows[i][1];
      rdv = rows[i][0] ? 32'h3 : 32'h0;
      run_case(rows[i][15:8], 1'b0, rdv);
    end
    // Shared by input only: a thread 1 event meets thread 0's user bit
    event_shared <= 1'b1;
    event_apic_lsb <= 1'b1;
    thread0_cpl <= 2'h3;
    run_case(8'h24, 1'b0, 32'h3);
    event_shared <= 1'b0;
    // Package power-saving stops non-sleep cycles
    pkg_power_save <= 1'b1;
    run_case(8'h60, 1'b0, 32'h0);
    pkg_power_save <= 1'b0;
    // Thread 0 alone awake, thread 1 halted: thread 0 non-halted cycles
    thread0_halted <= 1'b0;
    thread0_power_save <= 1'b1;
    run_case(8'h44, 1'b1, 32'h3);
    thread0_halted <= 1'b1;
    thread0_power_save <= 1'b0;
    // Time stamp holds in deep sleep, else steps each cycle
    pkg_deep_sleep <= 1'b1;
    rd(thread_count_pkg::OFF_STAMP, v1);
    repeat (4) @(posedge clock);
    rd(thread_count_pkg::OFF_STAMP, rdv);
    check(rdv, v1);
    pkg_deep_sleep <= 1'b0;
    rd(thread_count_pkg::OFF_STAMP, v1);
    repeat (4) @(posedge clock);
    rd(thread_count_pkg::OFF_STAMP, rdv);
    check(rdv, v1 + 32'h6);
    // Overflow while masked, then unmask, then clear
    pkg_sleep <= 1'b0;
    wr(thread_count_pkg::OFF_EVENT_SELECT, 32'h0000_0060);
    wr(thread_count_pkg::OFF_COUNT, 32'hffff_fffe);
    thread1_halted <= 1'b0;
    repeat (8) @(posedge clock);
    #1 check({31'h0, irq}, 32'h0);
    rd(thread_count_pkg::OFF_STATUS, rdv);
    check(rdv, 32'h1);
    wr(thread_count_pkg::OFF_MASK, 32'h1);
    wait_irq(1'b1);
    thread1_halted <= 1'b1;
    wr(thread_count_pkg::OFF_STATUS, 32'h1);
    wait_irq(1'b0);
    rd(thread_count_pkg::OFF_STATUS, rdv);
    check(rdv, 32'h0);
    // Overflow while unmasked, time stamp wrapping beside it
    wr(thread_count_pkg::OFF_STAMP, 32'hffff_ffff);
    wr(thread_count_pkg::OFF_COUNT, 32'hffff_fffe);
    thread1_halted <= 1'b0;
    wait_irq(1'b1);
    rd(thread_count_pkg::OFF_STATUS, rdv);
    check(rdv, 32'h3);
    // Second reset in mid-run clears the enable and the interrupt
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(thread_count_pkg::OFF_COUNTER_CFG, rdv);
    check(rdv, 32'h0);
    check({31'h0, irq}, 32'h0);
    stop_test();
  end
endmodule
